// ---- core/pdv_pkg.sv ----
// Package of register offsets, field layouts and codes for the pull-down and input monitor bank.
package pdv_pkg;

  // Register map, byte offsets on the internal register port.
  localparam logic [7:0] PDV_ADDR_LINEAR_REG_1TO4_PULLDOWN_CTRL = 8'h13;
  localparam logic [7:0] PDV_ADDR_LINEAR_REG_5_6_REF_BOOST_PULLDOWN_CTRL = 8'h14;
  localparam logic [7:0] PDV_ADDR_SWITCH_AND_INPUT_MONITOR_CTRL = 8'h15;

  // Values loaded at reset and on entering the check-and-load state.
  localparam logic [7:0] PDV_RESET_LINEAR_REG_1TO4 = 8'h00;
  localparam logic [7:0] PDV_RESET_LINEAR_REG_5_6_REF = 8'h00;
  localparam logic [7:0] PDV_RESET_SWITCH_MONITOR = 8'h00;

  // Value returned for an unmapped address.
  localparam logic [7:0] PDV_UNMAPPED_READ = 8'h00;

  // Pull-down select codes shared by all linear regulators and the reference.
  localparam logic [1:0] PDV_PD_SEL_AUTO = 2'h0;
  localparam logic [1:0] PDV_PD_SEL_OFF_A = 2'h1;
  localparam logic [1:0] PDV_PD_SEL_OFF_B = 2'h2;
  localparam logic [1:0] PDV_PD_SEL_FORCED = 2'h3;

  // Field layout of the regulator 1 to 4 register: two bits per regulator.
  localparam int PDV_PD_FIELD_W = 2;
  localparam int PDV_REG14_COUNT = 4;

  // Field layout of the regulator 5, 6, reference and boost register.
  localparam int PDV_REG5_LSB = 0;
  localparam int PDV_REG6_LSB = 2;
  localparam int PDV_DDR_REF_LSB = 4;
  localparam int PDV_BOOST_INHIBIT_BIT = 6;
  localparam logic [7:0] PDV_REG56_WRITE_MASK = 8'h7f;

  // Field layout of the switch and input monitor register.
  localparam int PDV_SWITCH_INPUT_ALWAYS_BIT = 7;
  localparam int PDV_SWITCH_OUTPUT_OFF_BIT = 6;
  localparam int PDV_HYST_LSB = 4;
  localparam int PDV_HYST_W = 2;
  localparam int PDV_THRESH_LSB = 1;
  localparam int PDV_THRESH_W = 3;
  localparam int PDV_MONITOR_EN_BIT = 0;

  // Input monitor figures in millivolts.
  localparam int PDV_MV_W = 9;
  localparam logic [8:0] PDV_HYST_BASE_MV = 9'h064;
  localparam logic [8:0] PDV_HYST_STEP_MV = 9'h064;
  localparam logic [8:0] PDV_THRESH_BASE_MV = 9'h032;
  localparam logic [8:0] PDV_THRESH_STEP_MV = 9'h032;

  // Channel count of the pull-down decoder array: regulators 1 to 6 and the reference.
  localparam int PDV_PD_CHANNELS = 7;

endpackage : pdv_pkg

// ---- core/pdv_pd_decode.sv ----
// One pull-down channel: turns a two-bit select and a live enable into the pull-down level.
`timescale 1ns/1ps
module pdv_pd_decode (
  input wire logic [1:0] sel,
  input wire logic output_enabled,
  output logic pulldown_on
);
  import pdv_pkg::*;

  // Purely combinational so the pull-down follows the enable with no added delay.
  assign pulldown_on = (sel == PDV_PD_SEL_FORCED) |
                       ((sel == PDV_PD_SEL_AUTO) & ~output_enabled);

endmodule : pdv_pd_decode

// ---- core/pdv_vin_decode.sv ----
// Input monitor decode: turns the hysteresis and offset codes into registered millivolt figures.
`timescale 1ns/1ps
module pdv_vin_decode (
  input wire logic clock,
  input wire logic reset,
  input wire logic [pdv_pkg::PDV_HYST_W-1:0] hyst_code,
  input wire logic [pdv_pkg::PDV_THRESH_W-1:0] thresh_code,
  output logic [pdv_pkg::PDV_MV_W-1:0] hyst_mv,
  output logic [pdv_pkg::PDV_MV_W-1:0] thresh_offset_mv
);
  import pdv_pkg::*;

  logic [PDV_MV_W-1:0] hyst_mv_d;
  logic [PDV_MV_W-1:0] hyst_mv_q;
  logic [PDV_MV_W-1:0] thresh_mv_d;
  logic [PDV_MV_W-1:0] thresh_mv_q;
  logic [17:0] hyst_prod;
  logic [17:0] thresh_prod;

  // Both scales are linear, so a base plus code times step replaces a lookup table.
  assign hyst_prod = 18'(hyst_code) * 18'(PDV_HYST_STEP_MV);
  assign thresh_prod = 18'(thresh_code) * 18'(PDV_THRESH_STEP_MV);
  assign hyst_mv_d = PDV_HYST_BASE_MV + hyst_prod[PDV_MV_W-1:0];
  assign thresh_mv_d = PDV_THRESH_BASE_MV + thresh_prod[PDV_MV_W-1:0];

  // The figures are registered; they lag the code by one clock.
  always_ff @(posedge clock) begin
    if (reset) begin
      hyst_mv_q <= PDV_HYST_BASE_MV;
      thresh_mv_q <= PDV_THRESH_BASE_MV;
    end else begin
      hyst_mv_q <= hyst_mv_d;
      thresh_mv_q <= thresh_mv_d;
    end
  end

  assign hyst_mv = hyst_mv_q;
  assign thresh_offset_mv = thresh_mv_q;

endmodule : pdv_vin_decode

// ---- core/pdv_cfg.sv ----
// Pull-down select and input monitor configuration bank of three host registers.
`timescale 1ns/1ps
module pdv_cfg (
  input wire logic clock,
  input wire logic reset,
  input wire logic check_load_entry,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rd_data,
  output logic reg_addr_hit,
  input wire logic [5:0] regulator_enable,
  input wire logic ddr_reference_enable,
  input wire logic boost_running,
  input wire logic switch_output_enable,
  output logic [5:0] regulator_pulldown,
  output logic ddr_reference_pulldown,
  output logic boost_pulldown,
  output logic switch_input_detect_en,
  output logic switch_output_detect_en,
  output logic low_input_monitor_enable,
  output logic [pdv_pkg::PDV_HYST_W-1:0] low_input_hysteresis,
  output logic [pdv_pkg::PDV_THRESH_W-1:0] low_input_threshold_offset,
  output logic [pdv_pkg::PDV_MV_W-1:0] low_input_hysteresis_mv,
  output logic [pdv_pkg::PDV_MV_W-1:0] low_input_threshold_offset_mv
);
  import pdv_pkg::*;

  // Stored register contents.
  logic [7:0] linear_reg_1to4_pulldown_ctrl_q;
  logic [7:0] linear_reg_1to4_pulldown_ctrl_d;
  logic [7:0] linear_reg_5_6_ref_boost_pulldown_ctrl_q;
  logic [7:0] linear_reg_5_6_ref_boost_pulldown_ctrl_d;
  logic [7:0] switch_and_input_monitor_ctrl_q;
  logic [7:0] switch_and_input_monitor_ctrl_d;
  logic [7:0] reg_rd_data_q;
  logic [7:0] reg_rd_data_d;

  // Address decode.
  logic hit_reg14;
  logic hit_reg56;
  logic hit_switch;
  logic wr_reg14;
  logic wr_reg56;
  logic wr_switch;

  // Decoded fields.
  logic [1:0] regulator1_pulldown_sel;
  logic [1:0] regulator2_pulldown_sel;
  logic [1:0] regulator3_pulldown_sel;
  logic [1:0] regulator4_pulldown_sel;
  logic [1:0] regulator5_pulldown_sel;
  logic [1:0] regulator6_pulldown_sel;
  logic [1:0] ddr_reference_pulldown_sel;
  logic boost_pulldown_inhibit;
  logic switch_input_detect_always;
  logic switch_output_detect_off;

  // Per-channel select and enable arrays for the decoder loop.
  logic [1:0] chan_sel [PDV_PD_CHANNELS];
  logic [PDV_PD_CHANNELS-1:0] chan_enabled;
  logic [PDV_PD_CHANNELS-1:0] chan_pulldown;

  // Each register answers at its own offset only; other addresses miss.
  assign hit_reg14 = (reg_addr == PDV_ADDR_LINEAR_REG_1TO4_PULLDOWN_CTRL);
  assign hit_reg56 = (reg_addr == PDV_ADDR_LINEAR_REG_5_6_REF_BOOST_PULLDOWN_CTRL);
  assign hit_switch = (reg_addr == PDV_ADDR_SWITCH_AND_INPUT_MONITOR_CTRL);
  assign reg_addr_hit = hit_reg14 | hit_reg56 | hit_switch;

  // Write strobes per register.
  assign wr_reg14 = reg_wr_en & hit_reg14;
  assign wr_reg56 = reg_wr_en & hit_reg56;
  assign wr_switch = reg_wr_en & hit_switch;

  // Next values: check-and-load entry beats a host write in the same cycle, because the
  // power state machine owns the bank while it reloads defaults.
  assign linear_reg_1to4_pulldown_ctrl_d =
    check_load_entry ? PDV_RESET_LINEAR_REG_1TO4 :
    wr_reg14 ? reg_wr_data : linear_reg_1to4_pulldown_ctrl_q;
  assign linear_reg_5_6_ref_boost_pulldown_ctrl_d =
    check_load_entry ? PDV_RESET_LINEAR_REG_5_6_REF :
    wr_reg56 ? (reg_wr_data & PDV_REG56_WRITE_MASK) :
    linear_reg_5_6_ref_boost_pulldown_ctrl_q;
  assign switch_and_input_monitor_ctrl_d =
    check_load_entry ? PDV_RESET_SWITCH_MONITOR :
    wr_switch ? reg_wr_data : switch_and_input_monitor_ctrl_q;

  // Read mux; an unmapped address reads as zero.
  assign reg_rd_data_d =
    !reg_rd_en ? reg_rd_data_q :
    hit_reg14 ? linear_reg_1to4_pulldown_ctrl_q :
    hit_reg56 ? linear_reg_5_6_ref_boost_pulldown_ctrl_q :
    hit_switch ? switch_and_input_monitor_ctrl_q :
    PDV_UNMAPPED_READ;

  // Register storage and read data; reset gives the same defaults as check-and-load.
  always_ff @(posedge clock) begin
    if (reset) begin
      linear_reg_1to4_pulldown_ctrl_q <= PDV_RESET_LINEAR_REG_1TO4;
      linear_reg_5_6_ref_boost_pulldown_ctrl_q <= PDV_RESET_LINEAR_REG_5_6_REF;
      switch_and_input_monitor_ctrl_q <= PDV_RESET_SWITCH_MONITOR;
      reg_rd_data_q <= 8'h00;
    end else begin
      linear_reg_1to4_pulldown_ctrl_q <= linear_reg_1to4_pulldown_ctrl_d;
      linear_reg_5_6_ref_boost_pulldown_ctrl_q <= linear_reg_5_6_ref_boost_pulldown_ctrl_d;
      switch_and_input_monitor_ctrl_q <= switch_and_input_monitor_ctrl_d;
      reg_rd_data_q <= reg_rd_data_d;
    end
  end

  assign reg_rd_data = reg_rd_data_q;

  // Regulator 1 to 4 selects, two bits each from the bottom up.
  assign regulator1_pulldown_sel = linear_reg_1to4_pulldown_ctrl_q[1:0];
  assign regulator2_pulldown_sel = linear_reg_1to4_pulldown_ctrl_q[3:2];
  assign regulator3_pulldown_sel = linear_reg_1to4_pulldown_ctrl_q[5:4];
  assign regulator4_pulldown_sel = linear_reg_1to4_pulldown_ctrl_q[7:6];

  // Regulator 5, 6 and reference selects plus the boost inhibit bit.
  assign regulator5_pulldown_sel =
    linear_reg_5_6_ref_boost_pulldown_ctrl_q[PDV_REG5_LSB +: PDV_PD_FIELD_W];
  assign regulator6_pulldown_sel =
    linear_reg_5_6_ref_boost_pulldown_ctrl_q[PDV_REG6_LSB +: PDV_PD_FIELD_W];
  assign ddr_reference_pulldown_sel =
    linear_reg_5_6_ref_boost_pulldown_ctrl_q[PDV_DDR_REF_LSB +: PDV_PD_FIELD_W];
  assign boost_pulldown_inhibit =
    linear_reg_5_6_ref_boost_pulldown_ctrl_q[PDV_BOOST_INHIBIT_BIT];

  // Switch and input monitor fields.
  assign switch_input_detect_always =
    switch_and_input_monitor_ctrl_q[PDV_SWITCH_INPUT_ALWAYS_BIT];
  assign switch_output_detect_off =
    switch_and_input_monitor_ctrl_q[PDV_SWITCH_OUTPUT_OFF_BIT];
  assign low_input_hysteresis =
    switch_and_input_monitor_ctrl_q[PDV_HYST_LSB +: PDV_HYST_W];
  assign low_input_threshold_offset =
    switch_and_input_monitor_ctrl_q[PDV_THRESH_LSB +: PDV_THRESH_W];
  assign low_input_monitor_enable =
    switch_and_input_monitor_ctrl_q[PDV_MONITOR_EN_BIT];

  // Channel arrays: indices 0 to 5 are regulators 1 to 6, index 6 is the reference.
  assign chan_sel[0] = regulator1_pulldown_sel;
  assign chan_sel[1] = regulator2_pulldown_sel;
  assign chan_sel[2] = regulator3_pulldown_sel;
  assign chan_sel[3] = regulator4_pulldown_sel;
  assign chan_sel[4] = regulator5_pulldown_sel;
  assign chan_sel[5] = regulator6_pulldown_sel;
  assign chan_sel[6] = ddr_reference_pulldown_sel;
  assign chan_enabled = {ddr_reference_enable, regulator_enable};

  // One decoder per channel; the same code table serves all seven outputs, and the
  // decode stays combinational so a disabled output is pulled down at once.
  for (genvar ch = 0; ch < PDV_PD_CHANNELS; ch++) begin : g_pd
    pdv_pd_decode u_pd (
      .sel(chan_sel[ch]),
      .output_enabled(chan_enabled[ch]),
      .pulldown_on(chan_pulldown[ch])
    );
  end

  // Regulators 1 to 4 and 5, 6 with the reference come out of the shared decoder.
  assign regulator_pulldown = chan_pulldown[5:0];
  assign ddr_reference_pulldown = chan_pulldown[6];

  // The boost bit is inverted: a set bit keeps the pull-down off while the boost is off.
  assign boost_pulldown = ~boost_running & ~boost_pulldown_inhibit;

  // Switch-input detector: tied to the output switch unless forced always on.
  assign switch_input_detect_en = switch_input_detect_always | switch_output_enable;

  // Switch-output detector runs unless software turns it off.
  assign switch_output_detect_en = ~switch_output_detect_off;

  // Millivolt figures for the analog trim, registered inside the decoder.
  pdv_vin_decode u_vin (
    .clock(clock),
    .reset(reset),
    .hyst_code(low_input_hysteresis),
    .thresh_code(low_input_threshold_offset),
    .hyst_mv(low_input_hysteresis_mv),
    .thresh_offset_mv(low_input_threshold_offset_mv)
  );

endmodule : pdv_cfg

// ---- sim/pdv_cfg_assertions.sv ----
// Port checker for the pull-down and input monitor bank.
`timescale 1ns/1ps
module pdv_cfg_chk
  import pdv_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic check_load_entry,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  input wire logic reg_addr_hit,
  input wire logic boost_running,
  input wire logic switch_output_enable,
  input wire logic [5:0] regulator_pulldown,
  input wire logic boost_pulldown,
  input wire logic switch_input_detect_en,
  input wire logic switch_output_detect_en,
  input wire logic low_input_monitor_enable,
  input wire logic [pdv_pkg::PDV_MV_W-1:0] low_input_hysteresis_mv
);
  // Writes that land; one lost to a simultaneous check-and-load is left out.
  wire logic wr_ok = reg_wr_en && !check_load_entry;
  wire logic wr13 = wr_ok && (reg_addr == 8'h13);
  wire logic wr14 = wr_ok && (reg_addr == 8'h14);
  wire logic wr15 = wr_ok && (reg_addr == 8'h15);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // Each property ties an output to the input event that sets it.
  property p_hit; reg_addr_hit == (reg_addr inside {8'h13, 8'h14, 8'h15}); endproperty
  a_hit: assert property (p_hit) else $error("address hit wrong");
  property p_rdz; reg_rd_en && !reg_addr_hit |=> reg_rd_data == 8'h00; endproperty
  a_rdz: assert property (p_rdz) else $error("unmapped read not zero");
  property p_clear; check_load_entry |=> !low_input_monitor_enable && switch_output_detect_en;
  endproperty
  a_clear: assert property (p_clear) else $error("load did not clear");
  property p_pd3; wr13 && reg_wr_data[1:0] == 2'h3 |=> regulator_pulldown[0]; endproperty
  a_pd3: assert property (p_pd3) else $error("forced pull-down off");
  property p_boost; wr14 && !reg_wr_data[6] |=> boost_pulldown == !boost_running; endproperty
  a_boost: assert property (p_boost) else $error("boost pull-down wrong");
  property p_swin; switch_output_enable |-> switch_input_detect_en; endproperty
  a_swin: assert property (p_swin) else $error("input detector off");
  property p_swout; wr15 |=> switch_output_detect_en == !$past(reg_wr_data[6]); endproperty
  a_swout: assert property (p_swout) else $error("output detector wrong");
  property p_hyst; wr15 |=> ##1 low_input_hysteresis_mv ==
    ({7'h00, $past(reg_wr_data[5:4], 2)} + 9'h001) * 9'h064; endproperty
  a_hyst: assert property (p_hyst) else $error("hysteresis figure wrong");
  c_wr15: cover property (wr15);
  c_load: cover property (check_load_entry);
  c_unmapped: cover property (reg_rd_en && !reg_addr_hit);
endmodule : pdv_cfg_chk

bind pdv_cfg pdv_cfg_chk i_chk (.clock(clock), .reset(reset),
  .check_load_entry(check_load_entry), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
  .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
  .reg_addr_hit(reg_addr_hit), .boost_running(boost_running),
  .switch_output_enable(switch_output_enable), .regulator_pulldown(regulator_pulldown),
  .boost_pulldown(boost_pulldown), .switch_input_detect_en(switch_input_detect_en),
  .switch_output_detect_en(switch_output_detect_en),
  .low_input_monitor_enable(low_input_monitor_enable),
  .low_input_hysteresis_mv(low_input_hysteresis_mv));

// ---- sim/pdv_host.sv ----
// Host model making single-byte register writes and reads.
`timescale 1ns/1ps
module pdv_host (
  input wire logic clock,
  input wire logic [7:0] reg_rd_data,
  output logic [7:0] reg_addr,
  output logic reg_wr_en,
  output logic [7:0] reg_wr_data,
  output logic reg_rd_en
);
  // Idle bus at time zero.
  initial begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en = 1'b0;
  end
  // Strobes last one cycle; released data flips so stale values are never trusted.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(negedge clock);
    reg_wr_en = 1'b0;
    reg_wr_data = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge clock);
    reg_rd_en = 1'b0;
    d = reg_rd_data;
  endtask : rd
endmodule : pdv_host

// ---- sim/tb_top.sv ----
// Self-checking bench for the pull-down and input monitor bank.
`timescale 1ns/1ps
module tb_top;
  import pdv_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic check_load_entry = 1'b0;
  logic [5:0] regulator_enable = 6'h00;
  logic ddr_reference_enable = 1'b0;
  logic boost_running = 1'b0;
  logic switch_output_enable = 1'b0;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data, rd_val;
  logic reg_wr_en, reg_rd_en, reg_addr_hit, ddr_pd, boost_pd, switch_input_det, switch_output_det, mon_en;
  logic [5:0] regulator_pulldown;
  logic [1:0] hyst;
  logic [2:0] thr;
  logic [8:0] hyst_mv, thr_mv;
  int m[3];
  int err_total = 0;
  int compares = 0;
  int v;
  // Clock of 8 ns period.
  always #4 clock = ~clock;
  pdv_cfg i_dut (.clock(clock), .reset(reset), .check_load_entry(check_load_entry),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .reg_addr_hit(reg_addr_hit),
    .regulator_enable(regulator_enable), .ddr_reference_enable(ddr_reference_enable),
    .boost_running(boost_running), .switch_output_enable(switch_output_enable),
    .regulator_pulldown(regulator_pulldown), .ddr_reference_pulldown(ddr_pd),
    .boost_pulldown(boost_pd), .switch_input_detect_en(switch_input_det),
    .switch_output_detect_en(switch_output_det), .low_input_monitor_enable(mon_en),
    .low_input_hysteresis(hyst), .low_input_threshold_offset(thr),
    .low_input_hysteresis_mv(hyst_mv), .low_input_threshold_offset_mv(thr_mv));
  pdv_host i_host (.clock(clock), .reg_rd_data(reg_rd_data), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en));
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Code 3 forces the pull-down on; code 0 lets it follow a low enable.
  function automatic logic pd(input int sel, input logic en);
    return sel == 3 || (sel == 0 && !en);
  endfunction : pd
  // Every decoded output against the model; the short wait lets inputs settle.
  task automatic chk_out();
    #1;
    for (int i = 0; i < 6; i++) begin
      chk(9'(regulator_pulldown[i]), 9'(pd((m[i/4] >> (2*(i%4))) & 3, regulator_enable[i])));
    end
    chk(9'(ddr_pd), 9'(pd((m[1] >> 4) & 3, ddr_reference_enable)));
    chk(9'(boost_pd), 9'(!m[1][6] && !boost_running));
    chk(9'(switch_input_det), 9'(m[2][7] || switch_output_enable));
    chk(9'(switch_output_det), 9'(!m[2][6]));
    chk(9'(mon_en), 9'(m[2][0]));
    chk(hyst_mv, 9'(100 * (((m[2] >> 4) & 3) + 1)));
    chk(thr_mv, 9'(50 * (((m[2] >> 1) & 7) + 1)));
    chk(9'(hyst), 9'((m[2] >> 4) & 3));
    chk(9'(thr), 9'((m[2] >> 1) & 7));
  endtask : chk_out
  task automatic rd_all();
    for (int k = 0; k < 3; k++) begin
      i_host.rd(8'(8'h13 + k), rd_val);
      chk(9'(rd_val), 9'(m[k]));
    end
    chk_out();
  endtask : rd_all
  // Write, read back, then move the live enables; unmapped places stay zero.
  task automatic rw(input logic [7:0] a, input logic [7:0] d);
    int k;
    k = (a >= 8'h13 && a <= 8'h15) ? int'(a) - 8'h13 : -1;
    i_host.wr(a, d);
    if (k >= 0) m[k] = (k == 1) ? d & 8'h7f : d;
    i_host.rd(a, rd_val);
    chk(9'(rd_val), 9'((k >= 0) ? m[k] : 0));
    chk(9'(reg_addr_hit), 9'(k >= 0));
    // No clock edge lies between this change and the check, so a registered pull-down fails.
    {regulator_enable, ddr_reference_enable, boost_running, switch_output_enable} = 9'($urandom);
    chk_out();
  endtask : rw
  task automatic close_out();
    $display("compares=%0d mismatches=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  // Main sequence.
  initial begin
    v = $urandom(66733);
    m = '{0, 0, 0};
    repeat (20) @(negedge clock);
    reset = 1'b0;
    rd_all();
    $display("test reset values done");
    for (int c = 0; c < 4; c++) begin
      rw(8'h13, {4{2'(c)}});
      rw(8'h14, {2'(c), {3{2'(c)}}});
      rw(8'h15, 8'($urandom));
    end
    $display("test all codes done");
    repeat (40) rw(8'h12 + 8'($urandom_range(0, 4)), 8'($urandom));
    $display("test random access done");
    @(negedge clock);
    reset = 1'b1;
    @(negedge clock);
    reset = 1'b0;
    m = '{0, 0, 0};
    rd_all();
    $display("test mid-run reset done");
    fork
      i_host.wr(8'h15, 8'hff);
      begin
        @(negedge clock);
        check_load_entry = 1'b1;
        @(negedge clock);
        check_load_entry = 1'b0;
      end
    join
    m = '{0, 0, 0};
    rd_all();
    $display("test check-and-load done");
    close_out();
  end
  // Watchdog far beyond the few hundred cycles the tests take.
  initial begin
    #100000;
    err_total++;
    close_out();
  end
endmodule : tb_top
